// *** hdl/psm_status_map.v ***
// Functional notes
// [RQ1] input bit 3: off on low input, alerts
// [RQ2] temp bits 7/6 fault/warn, alert, low zero
// [RQ3] comm bit 7: bad command or direction
// [RQ4] comm bit 6: invalid write data, masked
// [RQ5] comm bit 5: checksum byte mismatch, masked
// [RQ6] comm bit 1: internal link lost, masked
// [RQ7] other bit 1: isolator switch fault only
// [RQ8] vendor bits 3/2 standby under/over volt
// [RQ9] vendor bit 1: phase current imbalance
// [RQ10] vendor bit 0: output sag from bulk
// [RQ11] fan bit 7 fault, alerts, bits 6-4 and 2-0 zero
// [RQ12] fan bit 3: host speed override active
// [RQ13] 88h input voltage, exponent -1
// [RQ14] 89h input current, exponent -6
// [RQ15] 8Bh output voltage, exponent -9
// [RQ16] 8Ch output current, exponent -3
// [RQ17] 8Dh-8Fh three temperatures, exponent -2
// [RQ18] fan exponent 5, powers exponent 1
// [RQ19] 9Dh count plus four date chars
// [RQ20] D0h bit 0 clears store protection
// [RQ21] D5h eight ascii bytes, no count
// [RQ22] D9h seven mask bytes, no count
// [RQ23] flags latch until clear or cycling
// [RQ24] 03h no data, clears all status
// [RQ25] unimplemented bits read zero, never alert
// [RQ26] unmasked set flag pulls alert low
`include "psm_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module psm_status_map #(
  parameter [31:0] DATE_TEXT     = 32'h30303030, // arbitrary
  parameter [15:0] LOCATION_TEXT = 16'h3030,     // arbitrary
  parameter [15:0] FIRMWARE_REVISION_DIGITS_DIGITS = 16'h0000,     // arbitrary
  parameter [63:0] FW_TEXT       = 64'h30302e30302e3030
) (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  output wire        alert_out,
  output reg         alert_oe,
  input  wire [1:0]  addr_sel,
  input  wire        power_on_request_n,
  input  wire        input_power_ok,
  input  wire        vin_low_off,
  input  wire        overtemp_fault_flag,
  input  wire        overtemp_warn_flag,
  input  wire        internal_link_loss_flag,
  input  wire        output_isolator_fault_flag,
  input  wire        standby_undervolt_flag,
  input  wire        standby_overvolt_flag,
  input  wire        phase_imbalance_flag,
  input  wire        bulk_sag_regulation_flag,
  input  wire        cooler_failure_flag,
  input  wire        host_fan_speed_active,
  input  wire [10:0] vin_mant,
  input  wire [10:0] iin_mant,
  input  wire [10:0] vout_mant,
  input  wire [10:0] iout_mant,
  input  wire [10:0] t_inlet_mant,
  input  wire [10:0] t_outlet_mant,
  input  wire [10:0] t_iso_mant,
  input  wire [10:0] fan_mant,
  input  wire [10:0] pout_mant,
  input  wire [10:0] pin_mant,
  output reg         write_protect
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX   = 3'd1;
  localparam [2:0] ST_ACK  = 3'd2;
  localparam [2:0] ST_TX   = 3'd3;
  localparam [2:0] ST_RACK = 3'd4;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [5:0]  sync1, sync2;
  reg         scl_q, sda_q;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 6'h0b;
      sync2 <= 6'h0b;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      sync1 <= {addr_sel, input_power_ok, power_on_request_n, sda_in, scl_in};
      sync2 <= sync1;
      scl_q <= sync2[0];
      sda_q <= sync2[1];
    end
  end

  wire        scl      = sync2[0];
  wire        sda      = sync2[1];
  wire        pon_n    = sync2[2];
  wire        pwr_ok   = sync2[3];
  wire [6:0]  dev_addr = {`PSM_ADDR_BASE, sync2[5:4]};
  wire        start    = scl & scl_q & sda_q & ~sda;
  wire        stop     = scl & scl_q & ~sda_q & sda;
  wire        scl_rise = scl & ~scl_q;
  wire        scl_fall = ~scl & scl_q;

  assign sda_out   = 1'b0;
  assign alert_out = 1'b0;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [2:0]  state;
  reg  [3:0]  bitc, byte_n, snap_len, tx_idx;
  reg  [7:0]  sh, txsh, cmd, crc_all, crc_prev;
  reg  [63:0] wbuf, snap;
  reg         first, rd_mode, wr_pend, acked;
  reg         inv_cmd_ev, inv_data_ev, pec_ev, commit;
  reg  [55:0] mask;
  reg  [47:0] stat;

  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer     k;
    reg   [7:0] r;
    begin
      r = c ^ d;
      for (k = 0; k < 8; k = k + 1) begin
        r = r[7] ? ({r[6:0], 1'b0} ^ `PSM_CRC_POLY) : {r[6:0], 1'b0};
      end
      crc8 = r;
    end
  endfunction

  // ----------------------------------------
  // command lookup
  // ----------------------------------------
  reg  [63:0] next_snap;
  reg  [3:0]  next_len, wr_len;
  reg         known, rd_ok, wr_ok;
  integer     b;
  wire [7:0]  st_idx  = cmd - `PSM_CMD_ST_IN;
  wire [47:0] stat_sh = stat >> {st_idx[2:0], 3'b000};

  always @* begin
    next_snap = 64'h0;
    next_len  = `PSM_LEN_WORD;
    known     = 1'b1;
    rd_ok     = 1'b1;
    wr_ok     = 1'b0;
    wr_len    = 4'h0;
    case (cmd)
      `PSM_CMD_CLEAR: begin
        rd_ok    = 1'b0; // see [RQ24]
        wr_ok    = 1'b1;
        next_len = 4'h0;
      end
      `PSM_CMD_ST_IN, `PSM_CMD_ST_TEMP, `PSM_CMD_ST_COMM,
      `PSM_CMD_ST_OTH, `PSM_CMD_ST_VND, `PSM_CMD_ST_FAN: begin
        next_snap = {56'h0, stat_sh[7:0]};
        next_len  = `PSM_LEN_STAT;
      end
      `PSM_CMD_VIN:   next_snap = {48'h0, `PSM_EXP_VIN, vin_mant};        // see [RQ13]
      `PSM_CMD_IIN:   next_snap = {48'h0, `PSM_EXP_IIN, iin_mant};        // see [RQ14]
      `PSM_CMD_VOUT:  next_snap = {48'h0, `PSM_EXP_VOUT, vout_mant};      // see [RQ15]
      `PSM_CMD_IOUT:  next_snap = {48'h0, `PSM_EXP_IOUT, iout_mant};      // see [RQ16]
      `PSM_CMD_T_IN:  next_snap = {48'h0, `PSM_EXP_TEMP, t_inlet_mant};   // see [RQ17]
      `PSM_CMD_T_OUT: next_snap = {48'h0, `PSM_EXP_TEMP, t_outlet_mant};  // see [RQ17]
      `PSM_CMD_T_ISO: next_snap = {48'h0, `PSM_EXP_TEMP, t_iso_mant};     // see [RQ17]
      `PSM_CMD_FAN:   next_snap = {48'h0, `PSM_EXP_FAN, fan_mant};        // see [RQ18]
      `PSM_CMD_POUT:  next_snap = {48'h0, `PSM_EXP_PWR, pout_mant};       // see [RQ18]
      `PSM_CMD_PIN:   next_snap = {48'h0, `PSM_EXP_PWR, pin_mant};        // see [RQ18]
      `PSM_CMD_LOC:   next_snap = {48'h0, LOCATION_TEXT[7:0], LOCATION_TEXT[15:8]};
      `PSM_CMD_DATE: begin
        next_snap = {24'h0, DATE_TEXT[7:0], DATE_TEXT[15:8], DATE_TEXT[23:16],
                     DATE_TEXT[31:24], `PSM_DATE_CNT};                    // see [RQ19]
        next_len  = `PSM_LEN_DATE;
      end
      `PSM_CMD_FWREV: next_snap = {48'h0, FIRMWARE_REVISION_DIGITS_DIGITS};
      `PSM_CMD_CTRL: begin
        next_snap = {48'h0, 15'h0000, ~write_protect};                    // see [RQ20]
        wr_ok     = 1'b1;
        wr_len    = `PSM_LEN_WORD;
      end
      `PSM_CMD_FWTXT: begin
        for (b = 0; b < 8; b = b + 1) begin
          next_snap[b*8 +: 8] = FW_TEXT[(7-b)*8 +: 8];                   // see [RQ21]
        end
        next_len = `PSM_LEN_FWTXT;
      end
      `PSM_CMD_MASK: begin
        next_snap = {8'h00, mask};                                        // see [RQ22]
        next_len  = `PSM_LEN_MASK;
        wr_ok     = 1'b1;
        wr_len    = `PSM_LEN_MASK;
      end
      default: begin
        known    = 1'b0;
        rd_ok    = 1'b0;
        next_len = 4'h0;
      end
    endcase
  end

  wire [3:0]  n_data   = byte_n - 4'h1;
  wire [3:0]  last_i   = byte_n - 4'h2;
  wire [7:0]  last_b   = wbuf[{last_i[2:0], 3'b000} +: 8];
  wire        pec_ok   = (last_b == crc_prev);
  wire [3:0]  wr_len_p = wr_len + 4'h1;
  wire [2:0]  wi       = byte_n[2:0] - 3'h1;
  wire [63:0] snap_sh  = snap >> {tx_idx[2:0], 3'b000};
  // snapshot taken at address time keeps the bytes of one word coherent
  wire [7:0]  tx_byte  = (tx_idx < snap_len) ? snap_sh[7:0] : 8'hff;

  // ----------------------------------------
  // serial bus slave
  // ----------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_IDLE;
      bitc        <= 4'h0;
      sh          <= 8'h00;
      txsh        <= 8'h00;
      first       <= 1'b0;
      rd_mode     <= 1'b0;
      wr_pend     <= 1'b0;
      byte_n      <= 4'h0;
      cmd         <= 8'h00;
      wbuf        <= 64'h0;
      crc_all     <= 8'h00;
      crc_prev    <= 8'h00;
      snap        <= 64'h0;
      snap_len    <= 4'h0;
      tx_idx      <= 4'h0;
      acked       <= 1'b0;
      sda_oe      <= 1'b0;
      inv_cmd_ev  <= 1'b0;
      inv_data_ev <= 1'b0;
      pec_ev      <= 1'b0;
      commit      <= 1'b0;
    end else begin
      inv_cmd_ev  <= 1'b0;
      inv_data_ev <= 1'b0;
      pec_ev      <= 1'b0;
      commit      <= 1'b0;
      if (start) begin
        state   <= ST_RX;
        bitc    <= 4'h0;
        first   <= 1'b1;
        crc_all <= 8'h00;
        sda_oe  <= 1'b0;
      end else if (stop) begin
        state   <= ST_IDLE;
        sda_oe  <= 1'b0;
        wr_pend <= 1'b0;
        if (wr_pend && byte_n != 4'h0) begin
          if (!known) begin
            inv_cmd_ev <= 1'b1;                                 // see [RQ3]
          end else if (n_data == 4'h0) begin
            if (wr_ok && wr_len == 4'h0) begin
              commit <= 1'b1;                                   // see [RQ24]
            end
          end else if (!wr_ok) begin
            inv_cmd_ev <= 1'b1;                                 // see [RQ3]
          end else if (n_data == wr_len || (n_data == wr_len_p && pec_ok)) begin
            commit <= 1'b1;                                     // see [RQ22]
          end else begin
            inv_data_ev <= 1'b1;                                // see [RQ4]
            pec_ev      <= (n_data == wr_len_p);                // see [RQ5]
          end
        end
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], sda};
              bitc <= bitc + 4'h1;
            end else if (scl_fall && bitc == 4'h8) begin
              bitc     <= 4'h0;
              crc_prev <= crc_all;
              crc_all  <= crc8(crc_all, sh);
              if (first) begin
                first <= 1'b0;
                if (sh[7:1] == dev_addr) begin
                  state   <= ST_ACK;
                  sda_oe  <= 1'b1;
                  rd_mode <= sh[0];
                  wr_pend <= ~sh[0];
                  tx_idx  <= 4'h0;
                  if (!sh[0]) begin
                    byte_n <= 4'h0;
                  end else begin
                    snap       <= next_snap;
                    snap_len   <= next_len;
                    inv_cmd_ev <= ~rd_ok;                       // see [RQ3]
                  end
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                state  <= ST_ACK;
                sda_oe <= 1'b1;
                if (byte_n == 4'h0) begin
                  cmd <= sh;
                end else if (byte_n <= 4'h8) begin
                  wbuf[{wi, 3'b000} +: 8] <= sh;
                end
                if (byte_n != 4'hf) begin
                  byte_n <= byte_n + 4'h1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_mode) begin
                state  <= ST_TX;
                bitc   <= 4'h0;
                txsh   <= tx_byte;
                sda_oe <= ~tx_byte[7];
              end else begin
                state  <= ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitc == 4'h7) begin
                state  <= ST_RACK;
                sda_oe <= 1'b0;
              end else begin
                txsh   <= {txsh[6:0], 1'b0};
                sda_oe <= ~txsh[6];
                bitc   <= bitc + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              acked <= ~sda;
              if (!sda && tx_idx != 4'hf) begin
                tx_idx <= tx_idx + 4'h1;
              end
            end else if (scl_fall) begin
              if (acked) begin
                state  <= ST_TX;
                bitc   <= 4'h0;
                txsh   <= tx_byte;
                sda_oe <= ~tx_byte[7];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // control, masks and sticky status
  // ----------------------------------------
  wire        clr_cmd = commit & (cmd == `PSM_CMD_CLEAR);
  // holding clear while off means events during an off period show only while their flag is high,
  // and only because set wins over clear
  wire        clr_all = clr_cmd | ~pwr_ok | pon_n;                  // see [RQ23]

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      write_protect <= `PSM_WP_RST;
      mask          <= `PSM_MASK_RST;
    end else if (commit && cmd == `PSM_CMD_CTRL) begin
      write_protect <= ~wbuf[0];                                   // see [RQ20]
    end else if (commit && cmd == `PSM_CMD_MASK) begin
      mask          <= wbuf[55:0];                                 // see [RQ22]
    end
  end

  wire [47:0] set_vec = {
    cooler_failure_flag, 3'h0, host_fan_speed_active, 3'h0,  // see [RQ11], [RQ12]
    4'h0, standby_undervolt_flag, standby_overvolt_flag,     // see [RQ8]
    phase_imbalance_flag, bulk_sag_regulation_flag,          // see [RQ9], [RQ10]
    6'h00, output_isolator_fault_flag, 1'b0,                 // see [RQ7]
    inv_cmd_ev, inv_data_ev, pec_ev, 3'h0, internal_link_loss_flag, 1'b0, // see [RQ6]
    overtemp_fault_flag, overtemp_warn_flag, 6'h00,          // see [RQ2]
    4'h0, vin_low_off, 3'h0};
  wire [47:0] impl_vec = {`PSM_IMPL_FAN, `PSM_IMPL_VND, `PSM_IMPL_OTH,
                          `PSM_IMPL_COMM, `PSM_IMPL_TEMP, `PSM_IMPL_IN};
  wire [47:0] next_stat;

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_stat
      // set wins over clear so no event is lost in the clear cycle
      assign next_stat[i*8 +: 8] = (stat[i*8 +: 8] & {8{~clr_all}})
                                 | (set_vec[i*8 +: 8] & impl_vec[i*8 +: 8]); // see [RQ25]
    end
  endgenerate

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stat     <= 48'h0;
      alert_oe <= 1'b0;
    end else begin
      stat     <= next_stat;                                       // see [RQ1]
      alert_oe <= |(stat & mask[47:0]);                            // see [RQ26]
    end
  end

endmodule // psm_status_map

`default_nettype wire

// *** pkg/psm_regs.vh ***
`ifndef PSM_REGS_VH
`define PSM_REGS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define PSM_CMD_CLEAR   8'h03
`define PSM_CMD_ST_IN   8'h7c
`define PSM_CMD_ST_TEMP 8'h7d
`define PSM_CMD_ST_COMM 8'h7e
`define PSM_CMD_ST_OTH  8'h7f
`define PSM_CMD_ST_VND  8'h80
`define PSM_CMD_ST_FAN  8'h81
`define PSM_CMD_VIN     8'h88
`define PSM_CMD_IIN     8'h89
`define PSM_CMD_VOUT    8'h8b
`define PSM_CMD_IOUT    8'h8c
`define PSM_CMD_T_IN    8'h8d
`define PSM_CMD_T_OUT   8'h8e
`define PSM_CMD_T_ISO   8'h8f
`define PSM_CMD_FAN     8'h90
`define PSM_CMD_POUT    8'h96
`define PSM_CMD_PIN     8'h97
`define PSM_CMD_LOC     8'h9c
`define PSM_CMD_DATE    8'h9d
`define PSM_CMD_FWREV   8'hca
`define PSM_CMD_CTRL    8'hd0
`define PSM_CMD_FWTXT   8'hd5
`define PSM_CMD_MASK    8'hd9
// ----------------------------------------
// implemented status bits
// ----------------------------------------
`define PSM_IMPL_IN   8'h08
`define PSM_IMPL_TEMP 8'hc0
`define PSM_IMPL_COMM 8'he2
`define PSM_IMPL_OTH  8'h02
`define PSM_IMPL_VND  8'h0f
`define PSM_IMPL_FAN  8'h88
// mask bytes 0..6: input, temp, comm, other, vendor, fan, spare
`define PSM_MASK_RST  56'h0080000000c008
// ----------------------------------------
// linear-format exponents
// ----------------------------------------
`define PSM_EXP_VIN  5'h1f
`define PSM_EXP_IIN  5'h1a
`define PSM_EXP_VOUT 5'h17
`define PSM_EXP_IOUT 5'h1d
`define PSM_EXP_TEMP 5'h1e
`define PSM_EXP_FAN  5'h05
`define PSM_EXP_PWR  5'h01
// ----------------------------------------
// lengths, address, checksum
// ----------------------------------------
`define PSM_LEN_STAT  4'h1
`define PSM_LEN_WORD  4'h2
`define PSM_LEN_DATE  4'h5
`define PSM_DATE_CNT  8'h04
`define PSM_LEN_FWTXT 4'h8
`define PSM_LEN_MASK  4'h7
`define PSM_ADDR_BASE 5'h16
`define PSM_CRC_POLY  8'h07
`define PSM_WP_RST    1'b1
`endif

// *** bench/psm_status_map_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module psm_status_map_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic alert_oe,
  input wire logic power_on_request_n,
  input wire logic input_power_ok,
  input wire logic vin_low_off,
  input wire logic overtemp_fault_flag,
  input wire logic overtemp_warn_flag,
  input wire logic cooler_failure_flag,
  input wire logic write_protect
);
  // masks hold defaults until first start
  logic       no_start;
  logic       scl_q;
  logic       sda_q;
  logic [2:0] pwr_cnt;
  logic [2:0] low_cnt;
  logic [3:0] stop_cnt;
  logic [3:0] off_cnt;
  logic [3:0] unm_cnt;
  wire        unm = vin_low_off | overtemp_fault_flag | overtemp_warn_flag | cooler_failure_flag;
  wire        off = power_on_request_n | !input_power_ok;
  wire        arm = no_start && pwr_cnt == 3'h7;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      no_start <= 1'b1;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      pwr_cnt  <= 3'h0;
      low_cnt  <= 3'h0;
      stop_cnt <= 4'h0;
      off_cnt  <= 4'h0;
      unm_cnt  <= 4'h0;
    end else begin
      scl_q    <= scl_in;
      sda_q    <= sda_in;
      if (scl_q && scl_in && sda_q && !sda_in)
        no_start <= 1'b0;
      stop_cnt <= (scl_q && scl_in && !sda_q && sda_in) ? 4'hc :
                  (stop_cnt != 4'h0) ? stop_cnt - 4'h1 : 4'h0;
      off_cnt  <= off ? 4'hc : (off_cnt != 4'h0) ? off_cnt - 4'h1 : 4'h0;
      unm_cnt  <= unm ? 4'h6 : (unm_cnt != 4'h0) ? unm_cnt - 4'h1 : 4'h0;
      pwr_cnt  <= off ? 3'h0 : (pwr_cnt == 3'h7) ? 3'h7 : pwr_cnt + 3'h1;
      low_cnt  <= scl_in ? 3'h0 : (low_cnt == 3'h7) ? 3'h7 : low_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_vin_alert;
    arm && vin_low_off |-> ##[1:4] alert_oe;
  endproperty
  a_vin_alert: assert property (p_vin_alert)
    else $error("input low shutdown gave no alert");
  property p_temp_alert;
    arm && (overtemp_fault_flag || overtemp_warn_flag) |-> ##[1:4] alert_oe;
  endproperty
  a_temp_alert: assert property (p_temp_alert)
    else $error("temperature event gave no alert");
  property p_fan_alert;
    arm && cooler_failure_flag |-> ##[1:4] alert_oe;
  endproperty
  a_fan_alert: assert property (p_fan_alert)
    else $error("fan fault gave no alert");
  property p_masked_quiet;
    no_start && $rose(alert_oe) |-> unm_cnt != 4'h0;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("alert rose without an unmasked cause");
  property p_off_clears;
    (no_start && !unm && off) [*6] |-> !alert_oe;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("alert held while supply off");
  property p_alert_fall;
    $fell(alert_oe) |-> stop_cnt != 4'h0 || off_cnt != 4'h0;
  endproperty
  a_alert_fall: assert property (p_alert_fall)
    else $error("alert dropped with no clearing cause");
  property p_wp_change;
    !$stable(write_protect) |-> stop_cnt != 4'h0;
  endproperty
  a_wp_change: assert property (p_wp_change)
    else $error("protect changed outside a write");
  property p_sda_timing;
    !$stable(sda_oe) |-> !scl_in && low_cnt >= 3'h1 && low_cnt <= 3'h4;
  endproperty
  a_sda_timing: assert property (p_sda_timing)
    else $error("data line changed outside clock low");
endmodule // psm_status_map_sva
bind psm_status_map psm_status_map_sva u_sva (.*);
`default_nettype wire

// *** bench/psm_host_bfm.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus host model
// ----------------------------------------
module psm_host_bfm (
  input  wire logic mclk,
  input  wire logic dev_pull,
  output var  logic scl,
  output wire logic sda
);
  logic hold_low;
  // pull-up: a released line reads high, never the last value
  assign sda = !(hold_low || dev_pull);
  initial begin
    scl = 1'b1;
    hold_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // scl low for 12 cycles, twice the device minimum
  task automatic bit_io(input logic b, output logic s);
    hold_low = !b;
    tick(6);
    scl = 1'b1;
    tick(6);
    s = sda;
    tick(6);
    scl = 1'b0;
    tick(6);
  endtask
  task automatic start();
    hold_low = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    hold_low = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(6);
  endtask
  task automatic stop();
    hold_low = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    hold_low = 1'b0;
    tick(6);
  endtask
  // frames carry exactly the bytes the caller hands in, no count byte
  task automatic byte_io(input logic [7:0] tx, input logic ackbit,
                         output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ackbit, s);
    ack = !s;
  endtask
endmodule // psm_host_bfm
`default_nettype wire

// *** bench/test_psm_status_map.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.vh"
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module test_psm_status_map;
  localparam logic [63:0] FW = 64'h41302e31322e3334;
  localparam logic [31:0] DT = 32'h32343137;
  logic        mclk;
  logic        arst_n;
  logic        scl;
  wire         sda;
  logic        sda_oe;
  logic        alert_oe;
  logic        write_protect;
  logic [1:0]  addr_sel;
  logic        power_on_request_n;
  logic        input_power_ok;
  logic [10:0] flg;
  logic [10:0] mt [10];
  logic [7:0]  wb [8];
  logic [7:0]  rb [10];
  logic [7:0]  dev_w;
  int          st [6];
  int          mk [7] = '{8'h08, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  int          reg_of [11] = '{0, 1, 1, 2, 3, 4, 4, 4, 4, 5, 5};
  int          bit_of [11] = '{3, 7, 6, 1, 1, 3, 2, 1, 0, 7, 3};
  int          ex [10] = '{-1, -6, -9, -3, -2, -2, -2, 5, 1, 1};
  logic [7:0]  cd [10] = '{8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h90, 8'h96, 8'h97};
  int          err_total;
  int          check_count;
  int          cyc;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end
  psm_host_bfm host (.mclk(mclk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  psm_status_map #(.DATE_TEXT(DT), .FW_TEXT(FW)) dut (
    .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .alert_out(), .alert_oe(alert_oe), .addr_sel(addr_sel),
    .power_on_request_n(power_on_request_n), .input_power_ok(input_power_ok),
    .vin_low_off(flg[0]), .overtemp_fault_flag(flg[1]), .overtemp_warn_flag(flg[2]),
    .internal_link_loss_flag(flg[3]), .output_isolator_fault_flag(flg[4]),
    .standby_undervolt_flag(flg[5]), .standby_overvolt_flag(flg[6]),
    .phase_imbalance_flag(flg[7]), .bulk_sag_regulation_flag(flg[8]),
    .cooler_failure_flag(flg[9]), .host_fan_speed_active(flg[10]),
    .vin_mant(mt[0]), .iin_mant(mt[1]), .vout_mant(mt[2]), .iout_mant(mt[3]),
    .t_inlet_mant(mt[4]), .t_outlet_mant(mt[5]), .t_iso_mant(mt[6]), .fan_mant(mt[7]),
    .pout_mant(mt[8]), .pin_mant(mt[9]), .write_protect(write_protect));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic aexp();
    aexp = 1'b0;
    for (int i = 0; i < 6; i++)
      if ((st[i] & mk[i]) != 0) aexp = 1'b1;
  endfunction
  function automatic logic [7:0] crc8(input logic [31:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic snd(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    host.byte_io(b, 1'b1, r, a);
    chk("ack", a, 1'b1);
  endtask
  task automatic wr(input logic [7:0] cmd, input int n);
    host.start();
    snd(dev_w);
    snd(cmd);
    for (int i = 0; i < n; i++) snd(wb[i]);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n);
    logic a;
    host.start();
    snd(dev_w);
    snd(cmd);
    host.start();
    snd(dev_w | 8'h01);
    for (int i = 0; i < n; i++) host.byte_io(8'hff, i == n - 1, rb[i], a);
    host.stop();
  endtask
  task automatic pulse(input logic [10:0] f);
    flg = f;
    host.tick(1);
    flg = 11'h000;
    for (int i = 0; i < 11; i++)
      if (f[i]) st[reg_of[i]] |= 1 << bit_of[i];
    host.tick(5);
  endtask
  task automatic clr();
    wr(`PSM_CMD_CLEAR, 0);
    st = '{default: 0};
  endtask
  task automatic pcyc(input logic by_request);
    if (by_request)
      power_on_request_n = 1'b1;
    else
      input_power_ok = 1'b0;
    host.tick(8);
    power_on_request_n = 1'b0;
    input_power_ok = 1'b1;
    host.tick(8);
    st = '{default: 0};
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    logic a;
    void'($urandom(37));
    arst_n = 1'b0;
    addr_sel = 2'($urandom);
    power_on_request_n = 1'b0;
    input_power_ok = 1'b1;
    flg = 11'h000;
    for (int i = 0; i < 10; i++) mt[i] = 11'h000;
    dev_w = {5'h16, addr_sel, 1'b0};
    repeat (4) @(posedge mclk);
    #1 arst_n = 1'b1;
    host.tick(10);
    chk("protect", write_protect, 1'b1);
    // alert defaults with no traffic yet; alternate the two power clears
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << i);
      chk("alert", alert_oe, aexp());
      pcyc(i[0]);
      chk("alert", alert_oe, 1'b0);
    end
    // each flag latches into its own bit only
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << i);
      rd(8'h7c + 8'(reg_of[i]), 1);
      chk("status", rb[0], st[reg_of[i]]);
      clr();
      chk("alert", alert_oe, 1'b0);
    end
    rd(8'h01, 1);
    chk("unknown", rb[0], 8'hff);
    wb[0] = 8'h12;
    wb[1] = 8'h34;
    wr(`PSM_CMD_VIN, 2);
    wb[0] = 8'h01;
    wb[1] = 8'h00;
    wb[2] = crc8({dev_w, 8'hd0, 8'h01, 8'h00}) ^ 8'h01;
    wr(`PSM_CMD_CTRL, 3);
    chk("protect", write_protect, 1'b1);
    rd(`PSM_CMD_ST_COMM, 1);
    chk("comm", rb[0], 8'he0);
    chk("alert", alert_oe, 1'b0);
    clr();
    wb[0] = 8'hff;
    wb[1] = 8'hff;
    wb[2] = crc8({dev_w, 8'hd0, 8'hff, 8'hff});
    wr(`PSM_CMD_CTRL, 3);
    chk("protect", write_protect, 1'b0);
    rd(`PSM_CMD_CTRL, 2);
    chk("control", {rb[1], rb[0]}, 16'h0001);
    wb[0] = 8'h00;
    wb[1] = 8'h00;
    wr(`PSM_CMD_CTRL, 2);
    chk("protect", write_protect, 1'b1);
    for (int i = 0; i < 10; i++) begin
      mt[i] = 11'($urandom);
      rd(cd[i], 2);
      chk("reading", {rb[1], rb[0]}, {5'(ex[i]), mt[i]});
    end
    rd(`PSM_CMD_FWTXT, 9);
    for (int i = 0; i < 8; i++) chk("version", rb[i], FW[63 - 8 * i -: 8]);
    chk("past end", rb[8], 8'hff);
    rd(`PSM_CMD_DATE, 5);
    chk("count", rb[0], 8'h04);
    for (int i = 0; i < 4; i++) chk("date", rb[i + 1], DT[31 - 8 * i -: 8]);
    rd(`PSM_CMD_MASK, 7);
    for (int i = 0; i < 7; i++) chk("mask", rb[i], mk[i]);
    for (int i = 0; i < 7; i++) begin
      wb[i] = 8'($urandom);
      mk[i] = wb[i];
    end
    wr(`PSM_CMD_MASK, 7);
    rd(`PSM_CMD_MASK, 7);
    for (int i = 0; i < 7; i++) chk("mask", rb[i], mk[i]);
    pulse(11'($urandom));
    chk("alert", alert_oe, aexp());
    clr();
    chk("alert", alert_oe, 1'b0);
    host.start();
    host.byte_io(dev_w ^ 8'h80, 1'b1, rb[0], a);
    chk("foreign address", a, 1'b0);
    host.stop();
    stop_test();
  end
endmodule // test_psm_status_map
`default_nettype wire
